// file: rtl/ulf_pkg.sv
// Shared constants and carrier types for the line, flow and multidrop control block
package ulf_pkg;

  // ----------------------------------------------------------------
  // Field widths
  // ----------------------------------------------------------------
  localparam int unsigned MODE_W = 3;
  localparam int unsigned CHAR_W = 8;
  localparam int unsigned DELAY_W = 4;
  localparam int unsigned FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // Flow mode field encodings
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] FLOW_SW = 3'h2;
  localparam logic [MODE_W-1:0] FLOW_MD_FREE = 3'h3;
  localparam logic [MODE_W-1:0] FLOW_MD_GATED = 3'h4;

  // ----------------------------------------------------------------
  // Pin mode field encodings that hand the pin to direction control
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] PIN_XCVR_A = 3'h3;
  localparam logic [MODE_W-1:0] PIN_XCVR_B = 3'h4;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [DELAY_W-1:0] DELAY_NONE = 4'h0;
  localparam logic [DELAY_W-1:0] DELAY_LAST = 4'h1;
  localparam logic RX_EN_RST = 1'b1;
  localparam logic HALT_RST = 1'b0;

  // ----------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ninth;
    logic [CHAR_W-1:0] data;
  } ulf_rx_char_s;

  typedef struct packed {
    logic halted;
    logic rx_enabled;
    logic addr_matched;
  } ulf_status_s;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_LEAD,
    TX_SEND,
    TX_TAIL
  } ulf_tx_e;

endpackage

// file: rtl/ulf_fifo.sv
// Small shift-style FIFO with registered head, count and ready flags
`timescale 1ns/10ps
module ulf_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0] cnt;
    logic vld;
    logic rdy;
  } ulf_fifo_s;

  ulf_fifo_s st_ff;
  ulf_fifo_s nxt_st;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic push;
    logic pop;
    logic [CW-1:0] after_pop;
    push = 1'b0;
    pop = 1'b0;
    after_pop = '0;
    nxt_st = st_ff;
    // Head always sits in slot 0 so read data comes from a flop
    push = in_valid_i & st_ff.rdy;
    pop = out_ready_i & st_ff.vld;
    after_pop = pop ? CW'(st_ff.cnt - CW'(1)) : st_ff.cnt;
    if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        nxt_st.mem[i] = st_ff.mem[i+1];
      end
    end
    if (push)
    begin
      nxt_st.mem[after_pop] = in_data_i;
    end
    nxt_st.cnt = push ? CW'(after_pop + CW'(1)) : after_pop;
    nxt_st.vld = nxt_st.cnt != '0;
    nxt_st.rdy = nxt_st.cnt != CW'(DEPTH);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      st_ff <= '0;
      st_ff.rdy <= 1'b1;
    end
    else if (ce_i)
    begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready_o = st_ff.rdy;
  assign out_valid_o = st_ff.vld;
  assign out_data_o = st_ff.mem[0];

endmodule // ulf_fifo

// file: rtl/ulf_line_ctrl.sv
// Line control around a UART: software flow, transceiver direction, multidrop, half duplex
//
// What this block does
// - Software flow: received stop character halts sending after the current character
// - While halted, a received resume character lets sending continue
// - Software flow acts only when the flow mode field equals binary 010
// - Direction control drives the shared pin only in its pin modes
// - Transceiver enable goes active before any character is handed over
// - Enable drops after last stop bit, or 1 to 15 bit times later
// - pin_polarity_i picks the active level of transceiver enable
// - Flow modes 3 and 4 use resume/stop registers as unicast/multicast addresses
// - Ninth bit set marks an address; match is equality with either address
// - Matched address byte is dropped; following data bytes go to the FIFO
// - Unmatched address byte switches the receiver off
// - Flow mode 3 transmits whatever the address match state
// - Flow mode 4 transmits only after an address match
// - Half duplex set: received characters are ignored while sending
`timescale 1ns/10ps
module ulf_line_ctrl #(
  parameter int unsigned FIFO_DEPTH = ulf_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [ulf_pkg::MODE_W-1:0] flow_mode_i,
  input wire logic half_duplex_i,
  input wire logic [ulf_pkg::MODE_W-1:0] pin_mode_i,
  input wire logic pin_polarity_i,
  input wire logic [ulf_pkg::DELAY_W-1:0] turnaround_delay_register_i,
  input wire logic [ulf_pkg::CHAR_W-1:0] resume_char_i,
  input wire logic [ulf_pkg::CHAR_W-1:0] stop_char_i,
  input wire logic rx_char_valid_i,
  input wire ulf_pkg::ulf_rx_char_s rx_char_i,
  output logic rx_char_ready_o,
  output logic rx_fifo_valid_o,
  output logic [ulf_pkg::CHAR_W-1:0] rx_fifo_data_o,
  input wire logic rx_fifo_ready_i,
  input wire logic tx_data_valid_i,
  input wire logic tx_shift_busy_i,
  input wire logic tx_char_done_i,
  input wire logic bit_tick_i,
  output logic tx_load_o,
  output logic transceiver_enable_pin_o,
  output logic transceiver_enable_pin_oe_o,
  output ulf_pkg::ulf_status_s status_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ulf_pkg::ulf_tx_e tx_st;
    logic [ulf_pkg::DELAY_W-1:0] tail_cnt;
    ulf_pkg::ulf_status_s stat;
    logic load;
    logic pin;
    logic pin_oe;
  } ulf_ctrl_s;

  ulf_ctrl_s st_ff;
  ulf_ctrl_s nxt_st;

  logic fifo_in_ready;
  logic fifo_push;

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  function automatic logic is_multidrop(input logic [ulf_pkg::MODE_W-1:0] mode);
    is_multidrop = (mode == ulf_pkg::FLOW_MD_FREE) || (mode == ulf_pkg::FLOW_MD_GATED);
  endfunction

  function automatic logic is_xcvr_mode(input logic [ulf_pkg::MODE_W-1:0] mode);
    is_xcvr_mode = (mode == ulf_pkg::PIN_XCVR_A) || (mode == ulf_pkg::PIN_XCVR_B);
  endfunction

  function automatic logic addr_hit(
    input logic [ulf_pkg::CHAR_W-1:0] data,
    input logic [ulf_pkg::CHAR_W-1:0] unicast,
    input logic [ulf_pkg::CHAR_W-1:0] multicast
  );
    addr_hit = (data == unicast) || (data == multicast);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic rx_take;
    logic sw_flow;
    logic multidrop;
    logic xcvr;
    logic sending;
    logic permit;
    logic can_load;
    logic de;
    rx_take = 1'b0;
    sw_flow = 1'b0;
    multidrop = 1'b0;
    xcvr = 1'b0;
    sending = 1'b0;
    permit = 1'b0;
    can_load = 1'b0;
    de = 1'b0;
    nxt_st = st_ff;
    nxt_st.load = 1'b0;
    fifo_push = 1'b0;

    sw_flow = flow_mode_i == ulf_pkg::FLOW_SW;
    multidrop = is_multidrop(flow_mode_i);
    xcvr = is_xcvr_mode(pin_mode_i);
    sending = st_ff.tx_st == ulf_pkg::TX_SEND;
    // Characters are only taken while the FIFO has room, so none is lost to a full FIFO
    rx_take = rx_char_valid_i & fifo_in_ready;

    // Receive path
    if (rx_take)
    begin
      if (half_duplex_i && sending)
      begin
        fifo_push = 1'b0;
      end
      else if (multidrop)
      begin
        if (rx_char_i.ninth)
        begin
          // Address bytes never reach the FIFO, matched or not
          if (addr_hit(rx_char_i.data, resume_char_i, stop_char_i))
          begin
            nxt_st.stat.addr_matched = 1'b1;
            nxt_st.stat.rx_enabled = 1'b1;
          end
          else
          begin
            nxt_st.stat.rx_enabled = 1'b0;
          end
        end
        else
        begin
          fifo_push = st_ff.stat.rx_enabled;
        end
      end
      else
      begin
        fifo_push = 1'b1;
        if (sw_flow && rx_char_i.data == stop_char_i)
        begin
          nxt_st.stat.halted = 1'b1;
        end
        else if (sw_flow && rx_char_i.data == resume_char_i)
        begin
          nxt_st.stat.halted = 1'b0;
        end
      end
    end
    // A halt left over from software flow must not outlive the mode
    if (!sw_flow)
    begin
      nxt_st.stat.halted = ulf_pkg::HALT_RST;
    end

    // Transmit permission, checked only when a new character is handed over
    if (multidrop)
    begin
      permit = (flow_mode_i == ulf_pkg::FLOW_MD_GATED) ? st_ff.stat.addr_matched : 1'b1;
    end
    else
    begin
      permit = !(sw_flow && st_ff.stat.halted);
    end
    can_load = tx_data_valid_i & permit & ~st_ff.load;

    // Transmit sequencing and direction control
    case (st_ff.tx_st)
      ulf_pkg::TX_IDLE:
      begin
        if (can_load && !tx_shift_busy_i)
        begin
          if (xcvr)
          begin
            nxt_st.tx_st = ulf_pkg::TX_LEAD;
          end
          else
          begin
            nxt_st.load = 1'b1;
            nxt_st.tx_st = ulf_pkg::TX_SEND;
          end
        end
      end
      ulf_pkg::TX_LEAD:
      begin
        // Enable has been driven for one cycle before the load
        if (can_load)
        begin
          nxt_st.load = 1'b1;
          nxt_st.tx_st = ulf_pkg::TX_SEND;
        end
        else
        begin
          nxt_st.tx_st = ulf_pkg::TX_IDLE;
        end
      end
      ulf_pkg::TX_SEND:
      begin
        if (tx_char_done_i)
        begin
          if (can_load)
          begin
            nxt_st.load = 1'b1;
          end
          else if (xcvr && turnaround_delay_register_i != ulf_pkg::DELAY_NONE)
          begin
            nxt_st.tail_cnt = turnaround_delay_register_i;
            nxt_st.tx_st = ulf_pkg::TX_TAIL;
          end
          else
          begin
            nxt_st.tx_st = ulf_pkg::TX_IDLE;
          end
        end
      end
      ulf_pkg::TX_TAIL:
      begin
        if (can_load)
        begin
          nxt_st.load = 1'b1;
          nxt_st.tx_st = ulf_pkg::TX_SEND;
        end
        else if (bit_tick_i)
        begin
          if (st_ff.tail_cnt == ulf_pkg::DELAY_LAST)
          begin
            nxt_st.tx_st = ulf_pkg::TX_IDLE;
          end
          else
          begin
            nxt_st.tail_cnt = st_ff.tail_cnt - ulf_pkg::DELAY_LAST;
          end
        end
      end
      default:
      begin
        nxt_st.tx_st = ulf_pkg::TX_IDLE;
      end
    endcase

    // Pin follows the next state so enable and load stay aligned
    de = xcvr && (nxt_st.tx_st != ulf_pkg::TX_IDLE);
    nxt_st.pin = pin_polarity_i ? de : ~de;
    nxt_st.pin_oe = xcvr;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      st_ff <= '0;
      st_ff.tx_st <= ulf_pkg::TX_IDLE;
      st_ff.stat.halted <= ulf_pkg::HALT_RST;
      st_ff.stat.rx_enabled <= ulf_pkg::RX_EN_RST;
      st_ff.pin <= 1'b1;
    end
    else if (ce_i)
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  ulf_fifo #(
    .WIDTH(ulf_pkg::CHAR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .in_valid_i(fifo_push),
    .in_data_i(rx_char_i.data),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(rx_fifo_valid_o),
    .out_data_o(rx_fifo_data_o),
    .out_ready_i(rx_fifo_ready_i)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rx_char_ready_o = fifo_in_ready;
  assign tx_load_o = st_ff.load;
  assign transceiver_enable_pin_o = st_ff.pin;
  assign transceiver_enable_pin_oe_o = st_ff.pin_oe;
  assign status_o = st_ff.stat;

endmodule // ulf_line_ctrl

// file: tb/ulf_line_ctrl_checker.sv
// Concurrent checks on the ports of the line control block
`timescale 1ns/10ps
module ulf_line_ctrl_checker (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [ulf_pkg::MODE_W-1:0] flow_mode_i,
  input wire logic half_duplex_i,
  input wire logic [ulf_pkg::MODE_W-1:0] pin_mode_i,
  input wire logic pin_polarity_i,
  input wire logic [ulf_pkg::DELAY_W-1:0] turnaround_delay_register_i,
  input wire logic [ulf_pkg::CHAR_W-1:0] resume_char_i,
  input wire logic [ulf_pkg::CHAR_W-1:0] stop_char_i,
  input wire logic rx_char_valid_i,
  input wire ulf_pkg::ulf_rx_char_s rx_char_i,
  input wire logic rx_char_ready_o,
  input wire logic tx_data_valid_i,
  input wire logic tx_shift_busy_i,
  input wire logic tx_char_done_i,
  input wire logic tx_load_o,
  input wire logic transceiver_enable_pin_o,
  input wire logic transceiver_enable_pin_oe_o,
  input wire ulf_pkg::ulf_status_s status_o
);
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Half duplex excluded: a char taken while sending is dropped
  sequence s_addr;
    ce_i && rx_char_valid_i && rx_char_ready_o && !half_duplex_i && rx_char_i.ninth
    && (flow_mode_i == ulf_pkg::FLOW_MD_FREE || flow_mode_i == ulf_pkg::FLOW_MD_GATED);
  endsequence
  sequence s_last;
    ce_i && transceiver_enable_pin_oe_o && tx_char_done_i && !tx_data_valid_i;
  endsequence
  property p_rst;
    $fell(reset_i) |-> status_o == 3'h2 && !tx_load_o;
  endproperty
  a_rst: assert property (p_rst) else $error("state after reset wrong");
  property p_miss;
    s_addr ##0 (rx_char_i.data != resume_char_i && rx_char_i.data != stop_char_i)
    |=> !status_o.rx_enabled;
  endproperty
  a_miss: assert property (p_miss) else $error("receiver kept on");
  property p_hit;
    s_addr ##0 (rx_char_i.data == resume_char_i || rx_char_i.data == stop_char_i)
    |=> status_o.rx_enabled && status_o.addr_matched;
  endproperty
  a_hit: assert property (p_hit) else $error("address match lost");
  property p_free;
    tx_load_o |-> !$past(tx_shift_busy_i);
  endproperty
  a_free: assert property (p_free) else $error("load while shifter busy");
  property p_halt;
    !transceiver_enable_pin_oe_o && flow_mode_i == ulf_pkg::FLOW_SW && $past(status_o.halted)
    |-> !tx_load_o;
  endproperty
  a_halt: assert property (p_halt) else $error("load while halted");
  property p_gate;
    !transceiver_enable_pin_oe_o && flow_mode_i == ulf_pkg::FLOW_MD_GATED
    && !$past(status_o.addr_matched) |-> !tx_load_o;
  endproperty
  a_gate: assert property (p_gate) else $error("load before match");
  property p_oe;
    ce_i |=> transceiver_enable_pin_oe_o
    == ($past(pin_mode_i) == ulf_pkg::PIN_XCVR_A || $past(pin_mode_i) == ulf_pkg::PIN_XCVR_B);
  endproperty
  a_oe: assert property (p_oe) else $error("pin ownership wrong");
  property p_lead;
    tx_load_o && transceiver_enable_pin_oe_o |-> transceiver_enable_pin_o == pin_polarity_i
    && $past(transceiver_enable_pin_o) == pin_polarity_i;
  endproperty
  a_lead: assert property (p_lead) else $error("enable late at load");
  property p_tail0;
    s_last ##0 (turnaround_delay_register_i == ulf_pkg::DELAY_NONE)
    |=> transceiver_enable_pin_o != pin_polarity_i;
  endproperty
  a_tail0: assert property (p_tail0) else $error("enable not dropped");
  property p_tailn;
    s_last ##0 (turnaround_delay_register_i != ulf_pkg::DELAY_NONE)
    |=> transceiver_enable_pin_o == pin_polarity_i;
  endproperty
  a_tailn: assert property (p_tailn) else $error("enable dropped early");
endmodule // ulf_line_ctrl_checker

bind ulf_line_ctrl ulf_line_ctrl_checker u_chk (
  .sys_clk_i, .reset_i, .ce_i, .flow_mode_i, .half_duplex_i, .pin_mode_i, .pin_polarity_i,
  .turnaround_delay_register_i, .resume_char_i, .stop_char_i, .rx_char_valid_i, .rx_char_i,
  .rx_char_ready_o, .tx_data_valid_i, .tx_shift_busy_i, .tx_char_done_i, .tx_load_o,
  .transceiver_enable_pin_o, .transceiver_enable_pin_oe_o, .status_o
);

// file: tb/ulf_far_uart.sv
// Behavioural transmit shifter and bit clock on the serial side
`timescale 1ns/10ps
module ulf_far_uart #(
  parameter int unsigned TICK_DIV = 4,
  parameter int unsigned CHAR_BITS = 10
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic tx_load_i,
  output logic bit_tick_o,
  output logic busy_o,
  output logic done_o
);
  int div = 0;
  int bits = 0;
  initial
  begin
    bit_tick_o = 1'b0;
    busy_o = 1'b0;
    done_o = 1'b0;
  end
  // Done lands one cycle after a tick, the shifter is free from then on
  always @(posedge sys_clk_i)
  begin
    done_o <= 1'b0;
    if (reset_i)
    begin
      div <= 0;
      busy_o <= 1'b0;
      bit_tick_o <= 1'b0;
    end
    else
    begin
      div <= (div == TICK_DIV - 1) ? 0 : div + 1;
      bit_tick_o <= (div == TICK_DIV - 1);
      if (tx_load_i)
      begin
        busy_o <= 1'b1;
        bits <= CHAR_BITS;
      end
      else if (busy_o && bit_tick_o)
      begin
        bits <= bits - 1;
        if (bits == 1)
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule // ulf_far_uart

// file: tb/tb_top.sv
// Self-checking bench for the line control block
`timescale 1ns/10ps
`define EDGE @(posedge sys_clk_i)
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic [2:0] flow_mode_i = 3'h0, pin_mode_i = 3'h0;
  logic half_duplex_i = 1'b0, pin_polarity_i = 1'b1, rx_char_valid_i = 1'b0;
  logic rx_fifo_ready_i = 1'b1, tx_data_valid_i = 1'b0, tail_on = 1'b0;
  logic [3:0] turnaround_delay_register_i = 4'h0;
  logic [7:0] resume_char_i = 8'h11, stop_char_i = 8'h13, rx_fifo_data_o;
  ulf_pkg::ulf_rx_char_s rx_char_i = '0;
  ulf_pkg::ulf_status_s status_o;
  logic rx_char_ready_o, rx_fifo_valid_o, tx_shift_busy_i, tx_char_done_i, bit_tick_i;
  logic tx_load_o, transceiver_enable_pin_o, transceiver_enable_pin_oe_o;
  int error_cnt = 0, total_checks = 0, cyc = 0, load_cnt = 0, tick_n = 0, tail_ticks = -1, c;
  logic [7:0] got_q [$];
  logic [2:0] oth_t [5] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7};
  logic [2:0] pm_t [3] = '{3'h3, 3'h4, 3'h3};
  logic pol_t [3] = '{1'b1, 1'b0, 1'b1};
  logic [3:0] dl_t [3] = '{4'h0, 4'h1, 4'hF};

  ulf_line_ctrl #(.FIFO_DEPTH(ulf_pkg::FIFO_DEPTH)) dut (
    .sys_clk_i, .reset_i, .ce_i, .flow_mode_i, .half_duplex_i, .pin_mode_i,
    .pin_polarity_i, .turnaround_delay_register_i, .resume_char_i, .stop_char_i,
    .rx_char_valid_i, .rx_char_i, .rx_char_ready_o, .rx_fifo_valid_o, .rx_fifo_data_o,
    .rx_fifo_ready_i, .tx_data_valid_i, .tx_shift_busy_i, .tx_char_done_i, .bit_tick_i,
    .tx_load_o, .transceiver_enable_pin_o, .transceiver_enable_pin_oe_o, .status_o
  );
  ulf_far_uart far (.sys_clk_i, .reset_i, .tx_load_i(tx_load_o), .bit_tick_o(bit_tick_i),
    .busy_o(tx_shift_busy_i), .done_o(tx_char_done_i));

  // ----------------------------------------------------------------
  // Clock, monitors and watchdog
  // ----------------------------------------------------------------
  always #25 sys_clk_i = ~sys_clk_i;
  // Bit ticks counted from the last done pulse until the enable drops
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (rx_fifo_valid_o === 1'b1 && rx_fifo_ready_i === 1'b1) got_q.push_back(rx_fifo_data_o);
    if (tx_load_o === 1'b1) load_cnt++;
    if (tx_char_done_i === 1'b1)
    begin
      tail_on <= 1'b1;
      tick_n <= 0;
    end
    else if (tail_on && bit_tick_i === 1'b1) tick_n <= tick_n + 1;
    if (tail_on && tx_char_done_i !== 1'b1 && transceiver_enable_pin_o !== pin_polarity_i)
    begin
      tail_on <= 1'b0;
      tail_ticks <= tick_n;
    end
    if (cyc == 30000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  task automatic do_reset();
    `EDGE reset_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    tick(1);
  endtask
  // Char held until the edge that sees ready high
  task automatic send_rx(input logic nb, input logic [7:0] d);
    int n;
    `EDGE rx_char_valid_i <= 1'b1;
    rx_char_i <= '{ninth: nb, data: d};
    n = 0;
    @(negedge sys_clk_i);
    while (rx_char_ready_o !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge sys_clk_i);
    end
    `EDGE rx_char_valid_i <= 1'b0;
  endtask
  task automatic wait_load();
    int n, c0;
    c0 = load_cnt;
    n = 0;
    while (load_cnt == c0 && n < 300)
    begin
      n++;
      @(posedge sys_clk_i);
    end
    `CHK("load seen", 1'b1, n < 300)
  endtask
  task automatic expect_q(input logic [7:0] e [$]);
    `CHK("rx count", e.size(), got_q.size())
    foreach (e[i]) if (i < got_q.size()) `CHK("rx data", e[i], got_q[i])
    got_q.delete();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    `CHK("reset status", 3'h2, status_o)
    `EDGE rx_fifo_ready_i <= 1'b0;
    for (int i = 0; i < 4; i++) send_rx(1'b0, 8'h10 + 8'(i));
    tick(2);
    `CHK("fifo full", 1'b0, rx_char_ready_o)
    `EDGE rx_fifo_ready_i <= 1'b1;
    tick(8);
    expect_q('{8'h10, 8'h11, 8'h12, 8'h13});
    // Enable low must freeze the FIFO even with a char offered
    `EDGE ce_i <= 1'b0;
    rx_char_valid_i <= 1'b1;
    rx_char_i <= '{ninth: 1'b0, data: 8'h5A};
    tick(3);
    `CHK("frozen fifo", 1'b0, rx_fifo_valid_o)
    `EDGE rx_char_valid_i <= 1'b0;
    ce_i <= 1'b1;
    tick(3);
    `CHK("frozen drop", 0, got_q.size())
    `EDGE flow_mode_i <= ulf_pkg::FLOW_SW;
    tx_data_valid_i <= 1'b1;
    send_rx(1'b0, 8'h13);
    tick(50);
    c = load_cnt;
    tick(100);
    `CHK("halted", 1'b1, status_o.halted)
    `CHK("loads while halted", c, load_cnt)
    send_rx(1'b0, 8'h11);
    tick(60);
    `CHK("resumed", 1'b1, load_cnt > c)
    expect_q('{8'h13, 8'h11});
    foreach (oth_t[i])
    begin
      `EDGE flow_mode_i <= oth_t[i];
      send_rx(1'b0, 8'h13);
      c = load_cnt;
      tick(100);
      `CHK("not halted", 1'b1, load_cnt > c)
    end
    `EDGE tx_data_valid_i <= 1'b0;
    flow_mode_i <= 3'h0;
    got_q.delete();
    // Slowest tail is 15 bit times, so each case waits long enough
    foreach (pm_t[i])
    begin
      `EDGE pin_mode_i <= pm_t[i];
      pin_polarity_i <= pol_t[i];
      turnaround_delay_register_i <= dl_t[i];
      tick(50);
      `CHK("pin oe", 1'b1, transceiver_enable_pin_oe_o)
      `CHK("pin idle", ~pol_t[i], transceiver_enable_pin_o)
      `EDGE tx_data_valid_i <= 1'b1;
      wait_load();
      `EDGE tx_data_valid_i <= 1'b0;
      tick(120);
      `CHK("tail ticks", int'(dl_t[i]), tail_ticks)
    end
    `EDGE pin_mode_i <= 3'h0;
    tick(2);
    `CHK("pin oe", 1'b0, transceiver_enable_pin_oe_o)
    `EDGE flow_mode_i <= ulf_pkg::FLOW_MD_GATED;
    resume_char_i <= 8'h21;
    stop_char_i <= 8'h7E;
    tx_data_valid_i <= 1'b1;
    c = load_cnt;
    send_rx(1'b1, 8'h33);
    tick(1);
    `CHK("rx enabled", 1'b0, status_o.rx_enabled)
    send_rx(1'b0, 8'h44);
    tick(40);
    `CHK("gated", c, load_cnt)
    send_rx(1'b1, 8'h21);
    tick(1);
    `CHK("matched", 3'h3, status_o)
    send_rx(1'b0, 8'h45);
    send_rx(1'b1, 8'h7E);
    send_rx(1'b0, 8'h46);
    send_rx(1'b0, 8'h33);
    tick(60);
    `CHK("ungated", 1'b1, load_cnt > c)
    expect_q('{8'h45, 8'h46, 8'h33});
    `EDGE flow_mode_i <= ulf_pkg::FLOW_MD_FREE;
    do_reset();
    `CHK("reset status", 3'h2, status_o)
    c = load_cnt;
    tick(60);
    `CHK("free send", 1'b1, load_cnt > c)
    `EDGE flow_mode_i <= 3'h0;
    half_duplex_i <= 1'b1;
    wait_load();
    send_rx(1'b0, 8'h99);
    `EDGE tx_data_valid_i <= 1'b0;
    tick(100);
    send_rx(1'b0, 8'h98);
    tick(3);
    expect_q('{8'h98});
    tally_and_finish();
  end
endmodule // tb_top
